/* shared/csad_pkg.sv */
`default_nettype none
package csad_pkg;

	// ----------------------------------------------------------------
	// Opcodes and opcode fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_PREFIX = 8'h9e;
	localparam logic [7:0] OP_AIS    = 8'ha7;
	localparam logic [7:0] OP_AIX    = 8'haf;
	localparam logic [7:0] OP_BCC    = 8'h24;
	localparam logic [7:0] OP_BACKGROUND_ENTRY_INSTR   = 8'h82;
	localparam logic [3:0] LO_ADC    = 4'h9;
	localparam logic [3:0] LO_ADD    = 4'hb;
	localparam logic [3:0] HI_IMM    = 4'ha;
	localparam logic [3:0] HI_DIR    = 4'hb;
	localparam logic [3:0] HI_EXT    = 4'hc;
	localparam logic [3:0] HI_IX2    = 4'hd;
	localparam logic [3:0] HI_IX1    = 4'he;
	localparam logic [3:0] HI_IX     = 4'hf;

	// ----------------------------------------------------------------
	// Condition code bit positions and reset values
	// ----------------------------------------------------------------
	localparam int CCR_C = 0;
	localparam int CCR_Z = 1;
	localparam int CCR_N = 2;
	localparam int CCR_H = 4;
	localparam int CCR_V = 7;
	localparam logic [7:0]  CCR_RST = 8'h68;
	localparam logic [7:0]  A_RST   = 8'h00;
	localparam logic [15:0] SP_RST  = 16'h00ff;
	localparam logic [15:0] HX_RST  = 16'h0000;
	localparam logic [15:0] PC_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// Timing in bus cycles
	// ----------------------------------------------------------------
	localparam int BACKGROUND_ENTRY_INSTR_CYCLES = 5;
	localparam logic [2:0] BACKGROUND_ENTRY_INSTR_WAIT = 3'(BACKGROUND_ENTRY_INSTR_CYCLES - 2);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_BACKGROUND,
		CMD_GO,
		CMD_SINGLE_STEP,
		CMD_TAGGED_RESUME,
		CMD_ENABLE,
		CMD_DISABLE
	} csad_cmd_e_t;

	typedef enum logic [2:0] {
		M_IMM, M_DIR, M_EXT, M_IX2, M_IX1, M_IX, M_SP2, M_SP1
	} csad_mode_t;

	typedef struct packed {
		logic        valid;
		csad_cmd_e_t cmd;
	} csad_dbg_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
	} csad_bus_t;

	typedef struct packed {
		logic [7:0]  a;
		logic [15:0] hx;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  condition_code_reg;
	} csad_regs_t;

	typedef struct packed {
		logic background_entry_instr_active;
		logic stopped;
		logic osc_en;
		logic clk_en;
		logic debug_mode_enable;
	} csad_stat_t;

	typedef struct packed {
		logic [7:0] res;
		logic       v;
		logic       h;
		logic       n;
		logic       z;
		logic       c;
	} csad_alu_t;

endpackage
`default_nettype wire

/* hw/csad_adder.sv */
`timescale 1ns/10ps
`default_nettype none
module csad_adder (
	input  wire logic                 i_use_carry,
	input  wire logic                 i_cin,
	input  wire logic [7:0]           i_a,
	input  wire logic [7:0]           i_m,
	output var  csad_pkg::csad_alu_t  o_alu
);
	import csad_pkg::*;

	logic [8:0] sum;
	logic [4:0] low;
	logic       cin;

	always_comb begin
		cin = i_use_carry & i_cin;
		sum = {1'b0, i_a} + {1'b0, i_m} + {8'h00, cin};
		low = {1'b0, i_a[3:0]} + {1'b0, i_m[3:0]} + {4'h0, cin};
		o_alu.res = sum[7:0];
		o_alu.c = sum[8];
		o_alu.h = low[4];
		o_alu.n = sum[7];
		o_alu.z = (sum[7:0] == 8'h00);
		// Overflow only when both operands share a sign the result lacks.
		o_alu.v = (i_a[7] == i_m[7]) && (sum[7] != i_a[7]);
	end
endmodule // csad_adder
`default_nettype wire

/* hw/csad_core.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - In stop mode all clocks halt unless keep-clocks holds them for a periodic wake, or a host with debug_mode_enable set keeps the oscillator.
// - The oscillator stays on in stop mode while a host is present and debug_mode_enable is set.
// - A BACKGROUND command during stop with debug enabled and a host present restarts clocks and enters active background mode.
// - With debug_mode_enable set, the background_entry_instr stops user execution and places the core in active background mode.
// - Out of background mode only reset, GO, single_step_cmd or tagged_resume_cmd resume the user program.
// - With debug_mode_enable set, an opcode replaced by background_entry_instr acts as a software breakpoint and halts the program there.
// - Every instruction is sequenced in bus cycles with a fixed activity pattern per addressing mode.
// - Add with carry computes A = A + M + C for opcodes A9..F9 and the 9E-prefixed D9 and E9.
// - Add computes A = A + M for opcodes AB..FB and the 9E-prefixed DB and EB.
// - The stack_add_immediate_op A7 adds a signed immediate byte to SP in 2 bus cycles.
// - The index_add_immediate_op AF adds a signed immediate byte to H:X in 2 bus cycles.
// - The branch_carry_clear_op 24 branches when C is 0 and takes 3 program-fetch cycles.
// - Opcode 82 enters background mode only with debug_mode_enable set and takes at least 5 cycles.
module csad_core (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst_n,
	input  wire logic [7:0]             i_rdata,
	input  wire csad_pkg::csad_dbg_req_t i_dbg,
	input  wire logic                   i_host_present,
	input  wire logic                   i_debug_pin_strap,
	input  wire logic                   i_stop_req,
	input  wire logic                   i_stop_keep_clocks,
	input  wire logic                   i_periodic_wake,
	input  wire logic                   i_ext_wake,
	output var  csad_pkg::csad_bus_t    o_bus,
	output var  csad_pkg::csad_regs_t   o_regs,
	output var  csad_pkg::csad_stat_t   o_stat
);
	import csad_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_FETCH,
		ST_HI,
		ST_LO,
		ST_READ,
		ST_FREE,
		ST_WAIT,
		ST_BACKGROUND_ENTRY_INSTR,
		ST_STOP
	} csad_st_t;

	typedef struct packed {
		csad_st_t    st;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] hx;
		logic [7:0]  a;
		logic [7:0]  condition_code_reg;
		logic [7:0]  op;
		logic [7:0]  hi;
		logic        pre;
		logic        spm;
		logic [2:0]  cnt;
		logic        dbg_en;
		logic        step;
		logic        trap;
		logic [15:0] addr;
		logic        rd;
	} csad_core_t;

	csad_core_t s;
	csad_core_t next_s;
	csad_alu_t  alu;
	csad_mode_t mode;
	logic       do_alu;
	logic       cmd_bg;
	logic       cmd_resume;
	logic       cmd_step;
	logic       osc_forced;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] sext(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction

	function automatic csad_mode_t mode_of(input logic [3:0] hi, input logic spm);
		csad_mode_t m;
		m = M_IMM;
		case (hi)
			HI_IMM: m = M_IMM;
			HI_DIR: m = M_DIR;
			HI_EXT: m = M_EXT;
			HI_IX2: m = spm ? M_SP2 : M_IX2;
			HI_IX1: m = spm ? M_SP1 : M_IX1;
			HI_IX: m = M_IX;
			default: m = M_IMM;
		endcase
		return m;
	endfunction

	function automatic logic is_arith(input logic [7:0] op, input logic spm);
		logic lo_ok;
		logic hi_ok;
		lo_ok = (op[3:0] == LO_ADC) || (op[3:0] == LO_ADD);
		if (spm) begin
			hi_ok = (op[7:4] == HI_IX2) || (op[7:4] == HI_IX1);
		end else begin
			hi_ok = (op[7:4] >= HI_IMM);
		end
		return lo_ok && hi_ok;
	endfunction

	// ----------------------------------------------------------------
	// Adder
	// ----------------------------------------------------------------
	csad_adder u_adder (
		.i_use_carry (s.op[3:0] == LO_ADC),
		.i_cin       (s.condition_code_reg[CCR_C]),
		.i_a         (s.a),
		.i_m         (i_rdata),
		.o_alu       (alu)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rd = 1'b1;
		do_alu = 1'b0;
		mode = mode_of(s.op[7:4], s.spm);
		cmd_bg = i_dbg.valid && (i_dbg.cmd == CMD_BACKGROUND);
		cmd_step = i_dbg.valid && (i_dbg.cmd == CMD_SINGLE_STEP);
		cmd_resume = i_dbg.valid && ((i_dbg.cmd == CMD_GO) || (i_dbg.cmd == CMD_TAGGED_RESUME));
		// A host can only reach a sleeping core if its oscillator survives.
		osc_forced = i_host_present && s.dbg_en;
		if (i_dbg.valid && (i_dbg.cmd == CMD_ENABLE)) begin
			next_s.dbg_en = 1'b1;
		end else if (i_dbg.valid && (i_dbg.cmd == CMD_DISABLE)) begin
			next_s.dbg_en = 1'b0;
		end
		case (s.st)
			ST_FETCH: begin
				if (s.trap) begin
					next_s.trap = 1'b0;
					next_s.st = ST_BACKGROUND_ENTRY_INSTR;
					next_s.rd = 1'b0;
				end else if (cmd_bg && s.dbg_en && !s.pre) begin
					next_s.st = ST_BACKGROUND_ENTRY_INSTR;
					next_s.rd = 1'b0;
				end else if (i_stop_req && !s.pre) begin
					next_s.st = ST_STOP;
					next_s.rd = 1'b0;
				end else begin
					next_s.pc = s.pc + 16'h0001;
					next_s.addr = s.pc + 16'h0001;
					next_s.hi = 8'h00;
					next_s.op = i_rdata;
					next_s.spm = s.pre;
					next_s.pre = 1'b0;
					if (s.step) begin
						next_s.step = 1'b0;
						next_s.trap = 1'b1;
					end
					if ((i_rdata == OP_PREFIX) && !s.pre) begin
						// The prefix byte costs one program cycle of its own.
						next_s.pre = 1'b1;
						next_s.step = s.step;
						next_s.trap = 1'b0;
					end else if (is_arith(i_rdata, s.pre)) begin
						case (mode_of(i_rdata[7:4], s.pre))
							M_EXT, M_IX2, M_SP2: next_s.st = ST_HI;
							M_IX: begin
								next_s.st = ST_READ;
								next_s.addr = s.hx;
							end
							default: next_s.st = ST_LO;
						endcase
					end else if ((i_rdata == OP_AIS) || (i_rdata == OP_AIX)) begin
						next_s.st = ST_LO;
					end else if ((i_rdata == OP_BCC) && !s.pre) begin
						next_s.st = ST_LO;
					end else if ((i_rdata == OP_BACKGROUND_ENTRY_INSTR) && !s.pre) begin
						next_s.st = ST_WAIT;
						next_s.cnt = BACKGROUND_ENTRY_INSTR_WAIT;
						next_s.trap = 1'b0;
					end else begin
						next_s.st = ST_FETCH;
					end
				end
			end
			ST_HI: begin
				next_s.hi = i_rdata;
				next_s.pc = s.pc + 16'h0001;
				next_s.addr = s.pc + 16'h0001;
				next_s.st = ST_LO;
			end
			ST_LO: begin
				next_s.pc = s.pc + 16'h0001;
				next_s.addr = s.pc + 16'h0001;
				next_s.st = ST_FETCH;
				if (s.op == OP_AIS) begin
					next_s.sp = s.sp + sext(i_rdata);
				end else if (s.op == OP_AIX) begin
					next_s.hx = s.hx + sext(i_rdata);
				end else if (s.op == OP_BCC) begin
					next_s.st = ST_FREE;
					if (!s.condition_code_reg[CCR_C]) begin
						next_s.pc = s.pc + 16'h0001 + sext(i_rdata);
						next_s.addr = s.pc + 16'h0001 + sext(i_rdata);
					end
				end else if (mode == M_IMM) begin
					do_alu = 1'b1;
				end else begin
					next_s.st = ST_READ;
					case (mode)
						M_IX2, M_IX1: next_s.addr = s.hx + {s.hi, i_rdata};
						M_SP2, M_SP1: next_s.addr = s.sp + {s.hi, i_rdata};
						default: next_s.addr = {s.hi, i_rdata};
					endcase
				end
			end
			ST_READ: begin
				do_alu = 1'b1;
				next_s.addr = s.pc;
				// The no-offset form keeps its documented free cycle.
				next_s.st = (mode == M_IX) ? ST_FREE : ST_FETCH;
			end
			ST_FREE: begin
				next_s.addr = s.pc;
				next_s.st = ST_FETCH;
			end
			ST_WAIT: begin
				next_s.addr = s.pc;
				if (s.cnt == 3'h0) begin
					if (s.dbg_en) begin
						next_s.st = ST_BACKGROUND_ENTRY_INSTR;
						next_s.rd = 1'b0;
						// Resume lands on the breakpoint byte itself.
						next_s.pc = s.pc - 16'h0001;
					end else begin
						next_s.st = ST_FETCH;
					end
				end else begin
					next_s.cnt = s.cnt - 3'h1;
				end
			end
			ST_BACKGROUND_ENTRY_INSTR: begin
				next_s.rd = 1'b0;
				next_s.addr = s.pc;
				if (cmd_resume) begin
					next_s.st = ST_FETCH;
					next_s.rd = 1'b1;
				end else if (cmd_step) begin
					next_s.st = ST_FETCH;
					next_s.step = 1'b1;
					next_s.rd = 1'b1;
				end
			end
			ST_STOP: begin
				next_s.rd = 1'b0;
				if (cmd_bg && osc_forced) begin
					next_s.st = ST_BACKGROUND_ENTRY_INSTR;
				end else if (i_ext_wake || (i_periodic_wake && i_stop_keep_clocks)) begin
					next_s.st = ST_FETCH;
					next_s.rd = 1'b1;
				end
			end
			default: begin
				next_s.st = ST_FETCH;
				next_s.addr = s.pc;
			end
		endcase
		if (do_alu) begin
			next_s.a = alu.res;
			next_s.condition_code_reg[CCR_V] = alu.v;
			next_s.condition_code_reg[CCR_H] = alu.h;
			next_s.condition_code_reg[CCR_N] = alu.n;
			next_s.condition_code_reg[CCR_Z] = alu.z;
			next_s.condition_code_reg[CCR_C] = alu.c;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			s <= '0;
			s.pc <= PC_RST;
			s.addr <= PC_RST;
			s.sp <= SP_RST;
			s.hx <= HX_RST;
			s.a <= A_RST;
			s.condition_code_reg <= CCR_RST;
			// The strap is sampled throughout the synchronous reset.
			s.dbg_en <= i_debug_pin_strap;
			s.st <= i_debug_pin_strap ? ST_BACKGROUND_ENTRY_INSTR : ST_FETCH;
			s.rd <= ~i_debug_pin_strap;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		o_bus.addr = s.addr;
		o_bus.rd = s.rd;
		o_regs.a = s.a;
		o_regs.hx = s.hx;
		o_regs.sp = s.sp;
		o_regs.pc = s.pc;
		o_regs.condition_code_reg = s.condition_code_reg;
		o_stat.background_entry_instr_active = (s.st == ST_BACKGROUND_ENTRY_INSTR);
		o_stat.stopped = (s.st == ST_STOP);
		o_stat.debug_mode_enable = s.dbg_en;
		o_stat.clk_en = (s.st != ST_STOP) || i_stop_keep_clocks;
		o_stat.osc_en = (s.st != ST_STOP) || i_stop_keep_clocks
			|| (i_host_present && s.dbg_en);
	end
endmodule // csad_core
`default_nettype wire

/* sim/csad_core_props.sv */
`timescale 1ns/10ps
`default_nettype none
module csad_core_props
	import csad_pkg::*;
(
	input wire logic                    i_ref_clk,
	input wire logic                    i_rst_n,
	input wire logic [7:0]              i_rdata,
	input wire csad_pkg::csad_dbg_req_t i_dbg,
	input wire logic                    i_host_present,
	input wire logic                    i_debug_pin_strap,
	input wire logic                    i_stop_req,
	input wire logic                    i_stop_keep_clocks,
	input wire logic                    i_periodic_wake,
	input wire logic                    i_ext_wake,
	input wire csad_pkg::csad_bus_t     o_bus,
	input wire csad_pkg::csad_regs_t    o_regs,
	input wire csad_pkg::csad_stat_t    o_stat
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic bg_cmd;
	logic resume_cmd;
	logic held;
	assign bg_cmd = i_dbg.valid && i_dbg.cmd == CMD_BACKGROUND;
	assign resume_cmd = i_dbg.valid && (i_dbg.cmd == CMD_GO || i_dbg.cmd == CMD_SINGLE_STEP
		|| i_dbg.cmd == CMD_TAGGED_RESUME);
	assign held = o_stat.stopped && i_host_present && o_stat.debug_mode_enable;
	a_stop_osc_kept: assert property (held |-> o_stat.osc_en)
		else $error("oscillator off in stop with host attached");
	a_stop_osc_off: assert property (o_stat.stopped && !i_host_present && !i_stop_keep_clocks
		|-> !o_stat.osc_en) else $error("oscillator running in plain stop");
	a_stop_bus_idle: assert property (o_stat.stopped |-> !o_bus.rd)
		else $error("bus read while stopped");
	a_stop_bg_wake: assert property (held && bg_cmd |=> o_stat.background_entry_instr_active && !o_stat.stopped)
		else $error("background command did not wake stop");
	a_background_entry_instr_holds: assert property (o_stat.background_entry_instr_active && !resume_cmd |=> o_stat.background_entry_instr_active)
		else $error("background mode left without resume");
	a_background_entry_instr_no_fetch: assert property (o_stat.background_entry_instr_active |-> !o_bus.rd)
		else $error("fetch during background mode");
	a_background_entry_instr_regs_frozen: assert property (o_stat.background_entry_instr_active && $past(o_stat.background_entry_instr_active)
		&& $past(i_rst_n) |-> $stable(o_regs)) else $error("registers moved in background");
	a_go_fetch_pc: assert property (o_stat.background_entry_instr_active && i_dbg.valid && i_dbg.cmd == CMD_GO
		|=> !o_stat.background_entry_instr_active && o_bus.rd && o_bus.addr == $past(o_regs.pc))
		else $error("resume did not fetch at pc");
	a_dme_cmd: assert property (i_dbg.valid && (i_dbg.cmd == CMD_ENABLE || i_dbg.cmd == CMD_DISABLE)
		|=> o_stat.debug_mode_enable == ($past(i_dbg.cmd) == CMD_ENABLE))
		else $error("debug enable bit not updated");
endmodule // csad_core_props
bind csad_core csad_core_props csad_core_props_inst (.*);
`default_nettype wire

/* sim/csad_host.sv */
`timescale 1ns/10ps
`default_nettype none
module csad_host
	import csad_pkg::*;
(
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_attach,
	output var  csad_pkg::csad_dbg_req_t o_dbg,
	output logic                         o_host_present
);
	// Presence alone keeps the oscillator up only together with the enable bit.
	assign o_host_present = i_attach;
	initial o_dbg = '0;
	// One command per call, a single-cycle pulse launched off the falling edge.
	task automatic send(input csad_cmd_e_t c);
		@(negedge i_ref_clk);
		o_dbg = {1'b1, c};
		@(negedge i_ref_clk);
		o_dbg = {1'b0, CMD_NONE};
	endtask
endmodule // csad_host
`default_nettype wire

/* sim/cpu_stop_background_entry_instr_and_arith_decode_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_stop_background_entry_instr_and_arith_decode_tb_top;
	import csad_pkg::*;
	logic          clk = 0, rst_n = 0, strap = 0, stop = 0, keep = 0, pwake = 0, attach = 0;
	logic [7:0]    mem [0:255];
	logic [7:0]    rdata;
	csad_dbg_req_t dbg;
	logic          host;
	csad_bus_t     bus;
	csad_regs_t    regs;
	csad_stat_t    stat;
	int            n_mismatch = 0, checks_done = 0;
	logic [7:0]    a0, m1, sb, xb;
	logic [15:0]   e1, e2, pc_e;
	logic [7:0]    r [0:4];
	logic [15:0]   ea;
	assign rdata = mem[bus.addr[7:0]];
	initial forever #5 clk = ~clk;
	csad_host csad_host_inst (.i_ref_clk(clk), .i_attach(attach), .o_dbg(dbg),
		.o_host_present(host));
	csad_core csad_core_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_rdata(rdata), .i_dbg(dbg),
		.i_host_present(host), .i_debug_pin_strap(strap), .i_stop_req(stop),
		.i_stop_keep_clocks(keep), .i_periodic_wake(pwake), .i_ext_wake(1'b0),
		.o_bus(bus), .o_regs(regs), .o_stat(stat));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Returns the new accumulator above the condition codes, I and unused bits at reset value.
	function automatic logic [15:0] exp_add(logic [7:0] a, logic [7:0] m, logic ci);
		logic [8:0] s;
		logic [4:0] hs;
		s = {1'b0, a} + {1'b0, m} + 9'(ci);
		hs = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(ci);
		return {s[7:0], (a[7] == m[7]) && (s[7] != a[7]), 2'b11, hs[4], 1'b1, s[7],
			s[7:0] == 8'h00, s[8]};
	endfunction
	task automatic do_reset(input logic sv);
		@(negedge clk);
		rst_n = 0;
		strap = sv;
		repeat (3) @(negedge clk);
		rst_n = 1;
	endtask
	task automatic wait_stat(input int idx, input logic v);
		for (int k = 0; k < 30 && stat[idx] !== v; k++) @(negedge clk);
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		void'($urandom(94));
		for (int it = 0; it < 5; it++) begin
			{a0, m1, sb, xb} = $urandom;
			if (it == 0) {a0, m1} = 16'h01ff;
			foreach (mem[i]) mem[i] = 8'h00;
			{mem[0], mem[1], mem[2], mem[3], mem[4], mem[5]} = {8'hab, a0, 8'ha9, m1, 8'ha7, sb};
			{mem[6], mem[7], mem[8], mem[9]} = {8'haf, xb, 8'h24, 8'h02};
			{mem[10], mem[11], mem[12]} = {8'hab, 8'h00, 8'h82};
			do_reset(1'b0);
			if (it != 0) csad_host_inst.send(CMD_ENABLE);
			else @(negedge clk);
			repeat (9) @(negedge clk);
			e1 = exp_add(8'h00, a0, 1'b0);
			e2 = exp_add(e1[15:8], m1, e1[0]);
			pc_e = e2[0] ? 16'h000a : 16'h000c;
			chk("a", {8'h00, e2[15:8]}, {8'h00, regs.a});
			chk("ccr", {8'h00, e2[7:0]}, {8'h00, regs.condition_code_reg});
			chk("sp", SP_RST + {{8{sb[7]}}, sb}, regs.sp);
			chk("hx", HX_RST + {{8{xb[7]}}, xb}, regs.hx);
			chk("pc", pc_e, regs.pc);
			wait_stat(4, 1'b1);
			if (it == 0) begin
				chk("background_entry_instr_off", 16'h0000, {15'h0, stat.background_entry_instr_active});
				continue;
			end
			chk("background_entry_instr_pc", 16'h000c, regs.pc);
			csad_host_inst.send(CMD_GO);
			repeat (3) @(negedge clk);
			chk("background_entry_instr_left", 16'h0000, {15'h0, stat.background_entry_instr_active});
			wait_stat(4, 1'b1);
			chk("bp_again", 16'h000c, regs.pc);
		end
		// Memory-operand forms; the accumulator is read one edge early to pin the cycle count.
		foreach (mem[i]) mem[i] = 8'h00;
		foreach (r[i]) r[i] = 8'($urandom);
		{mem[0], mem[1], mem[2], mem[3], mem[4], mem[5], mem[6]} =
			{8'hbb, 8'h40, 8'hcb, 8'h00, 8'h41, 8'haf, 8'h42};
		{mem[7], mem[8], mem[9], mem[10], mem[11], mem[12], mem[13]} =
			{8'hfb, 8'heb, 8'h01, 8'h9e, 8'heb, 8'h45, 8'h82};
		{mem[8'h40], mem[8'h41], mem[8'h42], mem[8'h43], mem[8'h44]} = {r[0], r[1], r[2], r[3], r[4]};
		ea = exp_add(8'h00, r[0], 1'b0);
		for (int k = 1; k < 4; k++) ea = exp_add(ea[15:8], r[k], 1'b0);
		do_reset(1'b0);
		repeat (18) @(negedge clk);
		chk("a_early", {8'h00, ea[15:8]}, {8'h00, regs.a});
		ea = exp_add(ea[15:8], r[4], 1'b0);
		@(negedge clk);
		chk("a_modes", {8'h00, ea[15:8]}, {8'h00, regs.a});
		chk("ccr_modes", {8'h00, ea[7:0]}, {8'h00, regs.condition_code_reg});
		chk("pc_modes", 16'h000d, regs.pc);
		attach = 1;
		do_reset(1'b1);
		chk("strap_dme", 16'h0011, {11'h0, stat.background_entry_instr_active, 3'h0, stat.debug_mode_enable});
		stop = 1;
		csad_host_inst.send(CMD_GO);
		wait_stat(3, 1'b1);
		chk("osc_kept", 16'h0003, {14'h0, stat.stopped, stat.osc_en});
		csad_host_inst.send(CMD_BACKGROUND);
		chk("bg_wake", 16'h0002, {14'h0, stat.background_entry_instr_active, stat.stopped});
		csad_host_inst.send(CMD_DISABLE);
		attach = 0;
		csad_host_inst.send(CMD_GO);
		wait_stat(3, 1'b1);
		chk("osc_off", 16'h0002, {14'h0, stat.stopped, stat.osc_en});
		stop = 0;
		pwake = 1;
		repeat (4) @(negedge clk);
		chk("no_wake", 16'h0001, {15'h0, stat.stopped});
		keep = 1;
		wait_stat(3, 1'b0);
		chk("wake", 16'h0000, {15'h0, stat.stopped});
		give_verdict();
	end
endmodule // cpu_stop_background_entry_instr_and_arith_decode_tb_top
`default_nettype wire
